// [core/asl_consts.svh]
`ifndef ASL_CONSTS_SVH
`define ASL_CONSTS_SVH
// Number of multiplexed strap/LED pins
`define ASL_NPINS        3
// Address bit positions fed by each pin
`define ASL_BIT_LINK     2
`define ASL_BIT_TX       3
`define ASL_BIT_RX       4
// Pin slot indices inside the pin vectors
`define ASL_SLOT_LINK    0
`define ASL_SLOT_TX      1
`define ASL_SLOT_RX      2
// Width of the management address
`define ASL_ADDR_W       5
// Reset value of captured straps
`define ASL_STRAP_RST    3'h0
// Reset value of the management address bits
`define ASL_ADDR_RST     5'h00
// Reset value of the capture settle counter
`define ASL_CNT_RST      2'h0
// Settle count at which the capture strobe fires after reset release
`define ASL_CAP_CYCLES   2'h2
`endif

// [core/asl_pkg.sv]
package asl_pkg;
  // Pin sequencing phases
  typedef enum logic [1:0] {
    ASL_ST_INPUT,
    ASL_ST_CAPTURE,
    ASL_ST_OUTPUT
  } asl_state_t;
endpackage

// [core/asl_strap_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Capture strobe, synchronised levels and held straps between the pin logic and the strap register
interface asl_strap_if;
  logic       capture;   // One-cycle capture strobe
  logic [2:0] pin_level; // Synchronised pin levels
  logic [2:0] strap;     // Held strap levels
  modport ctrl (output capture, output pin_level, input strap);
  modport store (input capture, input pin_level, output strap);
endinterface
`default_nettype wire

// [core/asl_strap_reg.sv]
`timescale 1ns/1ps
`default_nettype none
`include "asl_consts.svh"
// Holds the strap levels captured at the end of hardware reset
module asl_strap_reg
  import asl_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rstn,
  asl_strap_if.store sif
);
  logic [2:0] strap_q; // Stored straps

  // Capture once per hardware reset, otherwise hold
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_q <= `ASL_STRAP_RST;
    end else if (sif.capture) begin
      strap_q <= sif.pin_level;
    end
  end

  assign sif.strap = strap_q;

  // Stored value changes only on a capture strobe
  property p_strap_hold;
    @(posedge clk) disable iff (!rstn)
    !sif.capture |=> $stable(strap_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap changed without capture");
endmodule
`default_nettype wire

// [core/asl_pins.sv]
`timescale 1ns/1ps
`default_nettype none
`include "asl_consts.svh"
// Summary of operation
// - Pins are inputs in reset, captured at exit.
// - After capture, pins become status outputs.
// - Low strap gives zero, high gives one.
// - Link pin sets address bit two.
// - Transmit pin sets address bit three.
// - Receive pin sets address bit four.
// - Link output follows valid link status.
// - Transmit output follows transmit activity.
// - Receive output follows receive activity.
// - Asserted level is inverse of strap.
// - Software reset keeps straps and outputs.
module asl_pins
  import asl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       sw_reset,
  input  wire logic       link_up,
  input  wire logic       tx_active,
  input  wire logic       rx_active,
  input  wire logic       addr_bit2_link_indicator_i,
  input  wire logic       addr_bit3_tx_indicator_i,
  input  wire logic       addr_bit4_rx_indicator_i,
  output logic            addr_bit2_link_indicator_o,
  output logic            addr_bit3_tx_indicator_o,
  output logic            addr_bit4_rx_indicator_o,
  output logic            addr_bit2_link_indicator_oe_n,
  output logic            addr_bit3_tx_indicator_oe_n,
  output logic            addr_bit4_rx_indicator_oe_n,
  output logic [4:0]      mgmt_addr_hi,
  output logic            straps_valid
);
  localparam int NP = `ASL_NPINS;

  asl_strap_if sif ();         // Link to strap store
  asl_state_t  state_q;        // Pin phase
  logic [1:0]  cnt_q;          // Capture settle counter
  logic [NP-1:0] sync1_q;      // First synchroniser stage
  logic [NP-1:0] sync2_q;      // Second synchroniser stage
  logic [NP-1:0] status;       // Status sources per pin
  logic [NP-1:0] led_q;        // Pin output levels
  logic [NP-1:0] oe_n_q;       // Pin output enables, low drives
  logic [4:0]    addr_q;       // Management address bits
  logic          valid_q;      // Straps captured

  // Elaboration check: slot and bit macros cover three pins only
  if (NP != 3) begin : g_np_check
    $error("asl_pins supports exactly three pins");
  end

  // Group status sources by pin slot
  assign status[`ASL_SLOT_LINK] = link_up;
  assign status[`ASL_SLOT_TX]   = tx_active;
  assign status[`ASL_SLOT_RX]   = rx_active;

  // Two-stage synchroniser on pin inputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= `ASL_STRAP_RST;
      sync2_q <= `ASL_STRAP_RST;
    end else begin
      sync1_q <= {addr_bit4_rx_indicator_i, addr_bit3_tx_indicator_i,
                  addr_bit2_link_indicator_i};
      sync2_q <= sync1_q;
    end
  end

  assign sif.pin_level = sync2_q;
  assign sif.capture   = (state_q == ASL_ST_CAPTURE) && (cnt_q == `ASL_CAP_CYCLES);

  // Phase sequencer; software reset is ignored here on purpose
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ASL_ST_INPUT;
      cnt_q   <= `ASL_CNT_RST;
    end else begin
      case (state_q)
        // Reset just released, begin sampling
        ASL_ST_INPUT: begin
          state_q <= ASL_ST_CAPTURE;
        end
        // Let synchroniser fill, then capture
        ASL_ST_CAPTURE: begin
          if (cnt_q == `ASL_CAP_CYCLES) begin
            state_q <= ASL_ST_OUTPUT;
          end else begin
            cnt_q <= cnt_q + 2'h1;
          end
        end
        // Stay outputs, even through software reset
        ASL_ST_OUTPUT: begin
          state_q <= ASL_ST_OUTPUT;
        end
        default: begin
          state_q <= ASL_ST_INPUT;
        end
      endcase
    end
  end

  // Per-pin drivers: released while sampling, inverted strap sense after
  for (genvar i = 0; i < NP; i++) begin : g_pin
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        led_q[i]  <= 1'h0;
        oe_n_q[i] <= 1'h1;
      end else if (state_q == ASL_ST_OUTPUT) begin
        oe_n_q[i] <= 1'h0;
        led_q[i]  <= status[i] ^ sif.strap[i];
      end else begin
        // Still sampling: keep the pin released
        led_q[i]  <= 1'h0;
        oe_n_q[i] <= 1'h1;
      end
    end
  end

  // Address bits follow captured straps directly
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_q  <= `ASL_ADDR_RST;
      valid_q <= 1'h0;
    end else if (sif.capture) begin
      addr_q[`ASL_BIT_LINK] <= sync2_q[`ASL_SLOT_LINK];
      addr_q[`ASL_BIT_TX]   <= sync2_q[`ASL_SLOT_TX];
      addr_q[`ASL_BIT_RX]   <= sync2_q[`ASL_SLOT_RX];
      valid_q               <= 1'h1;
    end
  end

  // Strap storage
  asl_strap_reg u_strap (
    .clk  (clk),
    .rstn (rstn),
    .sif  (sif)
  );

  assign addr_bit2_link_indicator_o    = led_q[`ASL_SLOT_LINK];
  assign addr_bit3_tx_indicator_o      = led_q[`ASL_SLOT_TX];
  assign addr_bit4_rx_indicator_o      = led_q[`ASL_SLOT_RX];
  assign addr_bit2_link_indicator_oe_n = oe_n_q[`ASL_SLOT_LINK];
  assign addr_bit3_tx_indicator_oe_n   = oe_n_q[`ASL_SLOT_TX];
  assign addr_bit4_rx_indicator_oe_n   = oe_n_q[`ASL_SLOT_RX];
  assign mgmt_addr_hi                  = addr_q;
  assign straps_valid                  = valid_q;

  // Pins not driven before straps are captured
  property p_input_before;
    @(posedge clk) disable iff (!rstn)
    !valid_q |-> (&oe_n_q);
  endproperty
  a_input_before: assert property (p_input_before) else $error("pin driven before capture");

  // Pins driven one cycle after valid
  property p_drive_after;
    @(posedge clk) disable iff (!rstn)
    $rose(valid_q) |=> (oe_n_q == 3'h0);
  endproperty
  a_drive_after: assert property (p_drive_after) else $error("pins not driven after capture");

  // Capture happens within a few cycles of reset release
  property p_capture_bound;
    @(posedge clk) disable iff (!rstn)
    (state_q == ASL_ST_INPUT) |-> ##[1:4] valid_q;
  endproperty
  a_capture_bound: assert property (p_capture_bound) else $error("capture too late");

  // Address bits equal synchronised levels at capture
  property p_addr_link;
    @(posedge clk) disable iff (!rstn)
    sif.capture |=> addr_q[`ASL_BIT_LINK] == $past(sync2_q[`ASL_SLOT_LINK]);
  endproperty
  a_addr_link: assert property (p_addr_link) else $error("address bit 2 wrong");

  property p_addr_tx;
    @(posedge clk) disable iff (!rstn)
    sif.capture |=> addr_q[`ASL_BIT_TX] == $past(sync2_q[`ASL_SLOT_TX]);
  endproperty
  a_addr_tx: assert property (p_addr_tx) else $error("address bit 3 wrong");

  property p_addr_rx;
    @(posedge clk) disable iff (!rstn)
    sif.capture |=> addr_q[`ASL_BIT_RX] == $past(sync2_q[`ASL_SLOT_RX]);
  endproperty
  a_addr_rx: assert property (p_addr_rx) else $error("address bit 4 wrong");

  // Link output level is link status xor strap
  property p_link_led;
    @(posedge clk) disable iff (!rstn)
    (state_q == ASL_ST_OUTPUT) |=>
      led_q[`ASL_SLOT_LINK] == ($past(link_up) ^ addr_q[`ASL_BIT_LINK]);
  endproperty
  a_link_led: assert property (p_link_led) else $error("link led level wrong");

  property p_tx_led;
    @(posedge clk) disable iff (!rstn)
    (state_q == ASL_ST_OUTPUT) |=>
      led_q[`ASL_SLOT_TX] == ($past(tx_active) ^ addr_q[`ASL_BIT_TX]);
  endproperty
  a_tx_led: assert property (p_tx_led) else $error("tx led level wrong");

  property p_rx_led;
    @(posedge clk) disable iff (!rstn)
    (state_q == ASL_ST_OUTPUT) |=>
      led_q[`ASL_SLOT_RX] == ($past(rx_active) ^ addr_q[`ASL_BIT_RX]);
  endproperty
  a_rx_led: assert property (p_rx_led) else $error("rx led level wrong");

  // Software reset leaves address and drive alone
  property p_sw_reset;
    @(posedge clk) disable iff (!rstn)
    (sw_reset && valid_q) |=> $stable(addr_q) && (oe_n_q == 3'h0);
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset disturbed pins");

  // Main scenarios
  c_capture: cover property (@(posedge clk) disable iff (!rstn) $rose(valid_q));
  c_link_on: cover property (@(posedge clk) disable iff (!rstn) valid_q && link_up);
  c_sw_rst:  cover property (@(posedge clk) disable iff (!rstn) valid_q && sw_reset);
endmodule
`default_nettype wire

// [verif/asl_board.sv]
`timescale 1ns/1ps
`default_nettype none
// Board side of each pin: a pull resistor in series with a status LED
module asl_board (
  input  wire logic [2:0] strap_lvl, // Rail the pull resistor goes to
  input  wire logic [2:0] drv,       // Level the device drives
  input  wire logic [2:0] drv_oe_n,  // Device drive enable, low drives
  output logic      [2:0] pin,       // Resolved pin level
  output logic      [2:0] led_on     // LED lit
);
  // Released pin falls to its pull rail, a driven pin shows the driver
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin[i] = drv_oe_n[i] ? strap_lvl[i] : drv[i];
    end
  end
  // LED lights only while the pin sits opposite its pull rail
  assign led_on = pin ^ strap_lvl;
endmodule
`default_nettype wire

// [verif/addr_strap_status_led_pins_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module addr_strap_status_led_pins_tb_top;
  logic       clk      = 1'h0; // Core clock
  logic       rstn     = 1'h0; // Hardware reset
  logic       sw_reset = 1'h0; // Software reset, must be ignored
  logic [2:0] st       = 3'h0; // Status: rx, tx, link
  logic [2:0] strap    = 3'h0; // Board pull levels
  logic [2:0] o;               // Pin drive levels
  logic [2:0] oe_n;            // Pin drive enables
  wire logic [2:0] pin;        // Resolved pins
  logic [2:0] led;             // LEDs lit
  logic [4:0] addr;            // Captured address
  logic       valid;           // Straps captured
  int         n_errors = 0;    // Mismatches
  int         n_checks = 0;    // Comparisons

  // Clock of 10 ns period
  always #5 clk = ~clk;

  asl_pins dut (
    .clk                          (clk),
    .rstn                         (rstn),
    .sw_reset                     (sw_reset),
    .link_up                      (st[0]),
    .tx_active                    (st[1]),
    .rx_active                    (st[2]),
    .addr_bit2_link_indicator_i   (pin[0]),
    .addr_bit3_tx_indicator_i     (pin[1]),
    .addr_bit4_rx_indicator_i     (pin[2]),
    .addr_bit2_link_indicator_o   (o[0]),
    .addr_bit3_tx_indicator_o     (o[1]),
    .addr_bit4_rx_indicator_o     (o[2]),
    .addr_bit2_link_indicator_oe_n(oe_n[0]),
    .addr_bit3_tx_indicator_oe_n  (oe_n[1]),
    .addr_bit4_rx_indicator_oe_n  (oe_n[2]),
    .mgmt_addr_hi                 (addr),
    .straps_valid                 (valid)
  );

  asl_board board (
    .strap_lvl(strap),
    .drv      (o),
    .drv_oe_n (oe_n),
    .pin      (pin),
    .led_on   (led)
  );

  // Compare one value and count it
  task automatic check(input logic [4:0] got, input logic [4:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hardware reset with a strap pattern, then capture and turn-around
  task automatic t_hw_reset(input logic [2:0] s);
    rstn  = 1'h0;
    strap = s;
    repeat (5) @(negedge clk);
    check({2'h0, oe_n}, 5'h07, "pins not inputs in reset");
    check({4'h0, valid}, 5'h00, "valid in reset");
    rstn = 1'h1;
    @(negedge clk);
    check({2'h0, oe_n}, 5'h07, "pins driven before capture");
    for (int i = 0; i < 10 && valid !== 1'h1; i++) @(negedge clk);
    check({4'h0, valid}, 5'h01, "straps never captured");
    check(addr, {s, 2'h0}, "captured address");
    @(negedge clk);
    check({2'h0, oe_n}, 5'h00, "pins not outputs");
  endtask

  // Every status combination, output inverted against the strap
  task automatic t_status(input logic [2:0] s);
    for (int v = 0; v < 8; v++) begin
      st = v[2:0];
      @(negedge clk);
      check({2'h0, o}, {2'h0, v[2:0] ^ s}, "pin level");
      check({2'h0, led}, {2'h0, v[2:0]}, "LED state");
    end
  endtask

  // Software reset must leave address and outputs alone
  task automatic t_sw_reset(input logic [2:0] s);
    sw_reset = 1'h1;
    st       = 3'h5;
    repeat (3) @(negedge clk);
    check({2'h0, oe_n}, 5'h00, "pins released in sw reset");
    check(addr, {s, 2'h0}, "address changed in sw reset");
    check({2'h0, o}, {2'h0, 3'h5 ^ s}, "status lost in sw reset");
    sw_reset = 1'h0;
    @(negedge clk);
  endtask

  // Main sequence over all eight strap patterns
  initial begin
    @(negedge clk);
    for (int s = 0; s < 8; s++) begin
      t_hw_reset(s[2:0]);
      t_status(s[2:0]);
      t_sw_reset(s[2:0]);
    end
    wrap_up();
  end

  // Watchdog well beyond the 177 cycles the run needs
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
